// ==== urte_ranger.sv ====
// Device side of the ranging trigger/echo handshake: burst, blanking,
// echo detection. Expects a synchronous trigger level and a
// synchronous comparator output from the analog receiver.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Trigger rising edge starts one burst cycle
// R2: Burst is exactly sixteen transducer pulses
// R3: Receiver blanked 2.38 ms from burst start
// R4: Detected reflection raises the echo output
// R5: Controller times trigger edge to echo edge
// R6: Controller computes distance as v*t/2
// R7: Controller corrects speed of sound for temperature
// R8: Controller holds trigger high until echo seen; the host model also drops it when go falls
// R9: Controller keeps trigger rate under 50 Hz
// R10: Controller never exceeds 100 Hz trigger rate
// R11: Trigger low returns echo low, ready again
module urte_ranger #(
  parameter int unsigned BLANK_CYCLES = urte_pkg::BLANK_CYC,
  parameter int unsigned HALF_TONE    = urte_pkg::HALF_TONE_CYC,
  parameter int unsigned PULSES       = urte_pkg::BURST_PULSES
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic trigIn,
  input  wire logic rxDetect,
  output var  logic txDrive,
  output var  logic rxEnable,
  output var  logic echoOut
);
  import urte_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (BLANK_CYCLES < 1 || HALF_TONE < 1 || PULSES < 1)
      $error("urte_ranger: counts must be at least one");
    // Edge counter is 8 bits, tone counter 16 bits wide
    if (PULSES > 128)
      $error("urte_ranger: PULSES must not exceed 128");
    if (HALF_TONE > 65536)
      $error("urte_ranger: HALF_TONE must not exceed 65536");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_BLANK, S_LISTEN, S_DONE} urte_state_t;

  urte_state_t state_reg,  state_next;
  logic        trigD_reg,  trigD_next;
  logic [31:0] timer_reg,  timer_next;
  logic [15:0] tone_reg,   tone_next;
  logic [7:0]  edges_reg,  edges_next;
  logic        tx_reg,     tx_next;
  logic        rxEn_reg,   rxEn_next;
  logic        echo_reg,   echo_next;

  // Level in, edge out; detector resets high
  logic trigRise;
  assign trigRise = trigIn & ~trigD_reg;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    trigD_next = trigIn;
    timer_next = timer_reg;
    tone_next  = tone_reg;
    edges_next = edges_reg;
    tx_next    = tx_reg;
    rxEn_next  = rxEn_reg;
    echo_next  = echo_reg;
    // Burst runs from the blanking start, independent of state
    if (edges_reg != 8'h00) begin
      if (tone_reg == 16'(HALF_TONE - 1)) begin
        tone_next  = 16'h0000;
        tx_next    = ~tx_reg;
        edges_next = edges_reg - 8'h01; // see R2
      end else begin
        tone_next = tone_reg + 16'h0001;
      end
    end
    case (state_reg)
      S_IDLE: begin
        if (trigRise) begin // see R1
          state_next = S_BLANK;
          timer_next = 32'h0000_0000;
          tone_next  = 16'h0000;
          tx_next    = 1'b1;
          edges_next = 8'(2 * PULSES - 1); // see R2
          rxEn_next  = 1'b0;
        end
      end
      S_BLANK: begin
        // Ringing would look like an echo; ignore receiver here
        if (timer_reg == 32'(BLANK_CYCLES - 1)) begin // see R3
          state_next = S_LISTEN;
          rxEn_next  = 1'b1;
        end else begin
          timer_next = timer_reg + 32'h0000_0001;
        end
      end
      S_LISTEN: begin
        if (rxDetect) begin // see R4
          state_next = S_DONE;
          echo_next  = 1'b1;
          rxEn_next  = 1'b0;
        end
      end
      S_DONE: ;
      default: state_next = S_IDLE;
    endcase
    // Trigger dropped: abandon cycle and clear echo
    if (!trigIn && state_reg != S_IDLE) begin // see R11
      state_next = S_IDLE;
      echo_next  = 1'b0;
      rxEn_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      trigD_reg <= 1'b1; // No false edge if trigger is high at reset
      timer_reg <= 32'h0000_0000;
      tone_reg  <= 16'h0000;
      edges_reg <= 8'h00;
      tx_reg    <= 1'b0;
      rxEn_reg  <= 1'b0;
      echo_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      trigD_reg <= trigD_next;
      timer_reg <= timer_next;
      tone_reg  <= tone_next;
      edges_reg <= edges_next;
      tx_reg    <= tx_next;
      rxEn_reg  <= rxEn_next;
      echo_reg  <= echo_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Plain copies, so each pin is a flop
  assign txDrive  = tx_reg;
  assign rxEnable = rxEn_reg;
  assign echoOut  = echo_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cleared on trigger rise so only this burst counts
  logic [7:0] riseCnt;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) riseCnt <= 8'h00;
    else if (trigRise && state_reg == S_IDLE) riseCnt <= 8'h00;
    else if (tx_next && !tx_reg) riseCnt <= riseCnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_trig_starts: assert property (@(posedge sys_clk) disable iff (!rstn) // see R1
    (trigRise && state_reg == S_IDLE) |=> (txDrive && state_reg == S_BLANK))
    else $error("trigger edge did not start burst");

  chk_pulse_count: assert property (@(posedge sys_clk) disable iff (!rstn) // see R2
    riseCnt <= 8'(PULSES - 1))
    else $error("burst longer than sixteen pulses");

  chk_blank_len: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
    (state_reg == S_BLANK && timer_reg < 32'(BLANK_CYCLES - 1) && trigIn)
      |=> !rxEnable)
    else $error("receiver enabled during blanking");

  chk_no_early_echo: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
    $rose(echoOut) |-> $past(rxEnable))
    else $error("echo raised outside receive mode");

  chk_echo_rise: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
    (state_reg == S_LISTEN && rxDetect && trigIn) |=> echoOut)
    else $error("detected reflection did not raise echo");

  chk_echo_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // see R11
    !trigIn |=> !echoOut)
    else $error("echo stayed high after trigger low");

  // Quiet, hold and ownership properties
  chk_burst_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // see R2
    (edges_reg == 8'h00) |-> !txDrive)
    else $error("transducer driven outside burst");

  chk_retrig_ignored: assert property (@(posedge sys_clk) disable iff (!rstn) // see R1
    (state_reg != S_IDLE && trigIn) |=> (state_reg != S_IDLE))
    else $error("cycle left while trigger held");

  chk_rx_listen: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
    rxEnable |-> (state_reg == S_LISTEN))
    else $error("receiver enabled outside receive mode");

  chk_echo_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
    (echoOut && trigIn) |=> echoOut)
    else $error("echo dropped while trigger high");

  chk_echo_cause: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
    $rose(echoOut) |-> $past(state_reg == S_LISTEN && rxDetect))
    else $error("echo raised without detected reflection");

  chk_rx_drop: assert property (@(posedge sys_clk) disable iff (!rstn) // see R11
    !trigIn |=> !rxEnable)
    else $error("receiver stayed on after trigger low");

endmodule : urte_ranger

`default_nettype wire

// ==== urte_pkg.sv ====
// Constants for the ultrasonic trigger/echo ranging block.
// Assumes a 250 MHz system clock; no software-visible registers.
`default_nettype none
package urte_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 250_000_000;

  // ----------------------------------------------------------------
  // Burst and blanking
  // ----------------------------------------------------------------
  localparam int unsigned BURST_PULSES  = 16;
  localparam int unsigned TONE_HZ       = 49_400;
  // Half tone period, rounded down so the tone never runs slow
  localparam int unsigned HALF_TONE_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned BLANK_NS      = 2_380_000;
  // Least time: round up
  localparam int unsigned BLANK_CYC     = (BLANK_NS + 3) / 4;

endpackage : urte_pkg

`default_nettype wire

// ==== urte_host_model.sv ====
// Controller model: raises the trigger on request and times the echo.
// Assumes the ranger samples its inputs on the sys_clk rising edge.
`timescale 1ns/1ps
`default_nettype none
module urte_host_model #(
  // Cycles between trigger rises; 50 Hz at 250 MHz
  parameter int MIN_GAP = 5_000_000,
  parameter int TEMP_C  = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic        echoOut,
  output var  logic        trigIn,
  output var  logic [15:0] tof,
  output var  logic [31:0] distA
);
  int gap;
  initial begin
    trigIn = 1'b0;
    tof    = 16'h0000;
    gap    = MIN_GAP;
  end
  always @(posedge sys_clk) begin
    if (go && !trigIn && gap >= MIN_GAP) begin
      trigIn <= 1'b1;
      tof    <= 16'h0000;
      gap    <= 0;
    end else begin
      if (gap < MIN_GAP) gap <= gap + 1;
      if (trigIn && (echoOut || !go)) trigIn <= 1'b0;
      else if (trigIn) tof <= tof + 16'h0001;
    end
  end
  // 0.1 nm units: tof * 4 ns * v / 2 with v in dm/s
  assign distA = 32'(tof) * 32'(2 * (3314 + 6 * TEMP_C));
endmodule : urte_host_model
`default_nettype wire

// ==== ultrasonic_range_trigger_echo_tb.sv ====
// Bench for urte_ranger: random echo delays, one aborted cycle.
// Assumes the host model owns the trigger; rxDetect is driven here.
`timescale 1ns/1ps
`default_nettype none
module ultrasonic_range_trigger_echo_tb;
  import urte_pkg::*;
  localparam int B = 20;
  localparam int T = 20;
  logic        sys_clk, rstn, go, rxDetect, trigIn;
  logic        txDrive, rxEnable, echoOut;
  logic [15:0] tof;
  logic [31:0] distA;
  int          err_count, total_checks, rises, d;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("Error %s exp %0d got %0d", n, e, g); end end
  urte_ranger #(.BLANK_CYCLES(B), .HALF_TONE(2)) dut (.sys_clk(sys_clk),
    .rstn(rstn), .trigIn(trigIn), .rxDetect(rxDetect), .txDrive(txDrive),
    .rxEnable(rxEnable), .echoOut(echoOut));
  urte_host_model #(.MIN_GAP(20), .TEMP_C(T)) host (.sys_clk(sys_clk),
    .go(go), .echoOut(echoOut), .trigIn(trigIn), .tof(tof), .distA(distA));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge txDrive) rises++;
  // Echo edge is the later of detect and end of blanking
  function automatic int exp_tof(int dl);
    return (dl + 1 > B + 2) ? dl + 1 : B + 2;
  endfunction : exp_tof
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic run(int dl, bit abort);
    int n;
    rises = 0;
    go = 1'b1;
    n = 0;
    while (!trigIn && n < 9) begin @(posedge sys_clk); #1 n++; end
    if (!trigIn) begin err_count++; print_verdict(); end
    repeat (dl) @(posedge sys_clk);
    #1 rxDetect = 1'b1;
    if (abort) go = 1'b0;
    n = 0;
    while (!echoOut && n < B + 80) begin @(posedge sys_clk); #1 n++; end
    if (abort) `CHK("echo", 0, echoOut)
    else begin
      if (!echoOut) begin err_count++; print_verdict(); end
      `CHK("tof", exp_tof(dl), tof)
      `CHK("dist", exp_tof(dl) * 2 * (3314 + 6 * T), distA)
    end
    go = 1'b0;
    rxDetect = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 `CHK("echo", 0, echoOut)
    `CHK("rxen", 0, rxEnable)
    repeat (70) @(posedge sys_clk);
    #1 `CHK("pulses", 16, rises)
    $display("run delay %0d abort %0d done", dl, abort);
  endtask : run
  initial begin
    {rstn, go, rxDetect} = 3'b000;
    err_count = 0;
    total_checks = 0;
    d = $urandom(33);
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1'b1;
    run(0, 1'b0);
    run(B + 3, 1'b0);
    run(5, 1'b1);
    repeat (4) run($urandom_range(B + 40), 1'b0);
    print_verdict();
  end
endmodule : ultrasonic_range_trigger_echo_tb
`default_nettype wire
